//--- err_reporter.sv
/* Command-side model: reports write stream errors and log reads.
   Assumes the same clock as the log block; fields follow the sequence number. */
`timescale 1ns/1ps
module err_reporter
(
   input  wire logic   clk_in,
   output logic        valid_out,
   output logic [15:0] feature_out,
   output logic [7:0]  status_out,
   output logic [7:0]  error_out,
   output logic [47:0] lba_out,
   output logic [15:0] count_out,
   output logic        done_out
);
   // Quiet at time zero
   initial
   begin
      {valid_out, feature_out, status_out, error_out, lba_out, count_out, done_out} = '0;
   end
   // One strobe per cycle; idle feature, status and error fields are inverted so stale values never match
   task send(input int m0, input int n, input logic flag);
      int m;
      for (int i = 0; i < n; i++)
      begin
         m = m0 + i;
         @(posedge clk_in);
         valid_out   <= 1'b1;
         feature_out <= m[15:0];
         status_out  <= flag ? 8'h21 : 8'h01;
         error_out   <= 8'h04;
         lba_out     <= {16'h00AB, 16'h5A5A, m[15:0]};
         count_out   <= m[15:0] + 16'h0001;
      end
      @(posedge clk_in);
      valid_out <= 1'b0;
      {feature_out, status_out, error_out} <= ~{feature_out, status_out, error_out};
   endtask : send
   task done_pulse();
      @(posedge clk_in);
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
   endtask : done_pulse
endmodule : err_reporter

//--- stream_error_and_identify_log.sv
/*
 * Write stream error log and identify device data log pages, read over
 * APB as 32-bit little-endian words of the 512-byte structures.
 * Assumes the error strobe and identify loader share SYS_CLK_IN and that
 * command logic pulses the read-done input after a good log 21h read.
 */
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Log only errors with stream error flag
// - Log is 512 bytes, 31 entries
// - Count all errors since last log read
// - Error count saturates at its maximum
// - Successful log read clears index and count
// - Power-on or hardware reset empties log
// - Header fields then 16-byte entries from 10h
// - Version byte always reads 02h
// - Index names newest entry, range 31:0
// - Identify log read-only, writes ignored
// - Unsupported page reports revision 0000h
// - Bytes past defined fields read reserved
// - Page numbers 00h list, 01h copy, 02h capacity
// - Supported page list is ascending
// - List header, count at byte 8
// - Page 01h copies identify words 0..255
// - Capacity header bit63, page 02h, rev 0001h
// - Capacity quadword bit63 and 48-bit capacity
// - Sector size quadword fields and flags
// - Logical sector size valid flag, low 32 bits
// - Buffer size valid flag, bits 62:0
// - Entry holds feature, status, error, address, count
module stream_error_and_identify_log
(
   input  wire logic        SYS_CLK_IN,          // System clock, 100 MHz
   input  wire logic        RESET_IN,            // Synchronous reset, active high
   input  wire logic        PSEL_IN,             // APB select
   input  wire logic        PENABLE_IN,          // APB access phase
   input  wire logic        PWRITE_IN,           // APB direction
   input  wire logic [11:0] PADDR_IN,            // APB byte address
   input  wire logic [31:0] PWDATA_IN,           // APB write data
   output logic      [31:0] PRDATA_OUT,          // APB read data
   output logic             PREADY_OUT,          // APB ready
   output logic             PSLVERR_OUT,         // APB error on unmapped address
   input  wire logic        WS_ERR_VALID_IN,     // One-cycle write stream error strobe
   input  wire logic [15:0] WS_ERR_FEATURE_IN,   // Feature, previous in 15:8
   input  wire logic [7:0]  WS_ERR_STATUS_IN,    // Status at the error
   input  wire logic [7:0]  WS_ERR_ERROR_IN,     // Error at the error
   input  wire logic [47:0] WS_ERR_LBA_IN,       // Starting block address
   input  wire logic [15:0] WS_ERR_COUNT_IN,     // Sector count of the error
   input  wire logic        LOG_READ_DONE_IN,    // Pulse: log 21h read completed
   input  wire logic        ID_WR_EN_IN,         // Identify data word load strobe
   input  wire logic [7:0]  ID_WR_WORD_IN,       // Identify word number
   input  wire logic [15:0] ID_WR_DATA_IN,       // Identify word value
   output logic      [15:0] LOG_COUNT_OUT,       // Current error count
   output logic      [4:0]  LOG_INDEX_OUT        // Current newest entry number
);

   // Error entry storage, one 128-bit slot per entry number minus one
   // Slot k is entry k+1
   logic [127:0]                                     entry_mem [stream_log_pkg::LOG_ENTRIES];
   logic [stream_log_pkg::LOG_ENTRIES-1:0]           slot_used_r;   // Slot holds a live entry
   logic [stream_log_pkg::LOG_ENTRIES-1:0]           slot_used_nxt;
   logic [15:0]                                      count_r;       // Errors since last clear
   logic [15:0]                                      count_nxt;
   logic [4:0]                                       index_r;       // Newest entry number, 0 empty
   logic [4:0]                                       index_nxt;

   // Identify device data copy, loaded by the drive controller
   // Not reset; loader fills it
   logic [15:0]                                      id_mem [stream_log_pkg::ID_WORDS];

   // Software configuration
   // All reset to zero
   logic [7:0]                                       page_sel_r;    // Identify page on view
   logic [31:0]                                      cap_lo_r;      // Capacity low word
   logic [15:0]                                      cap_hi_r;      // Capacity high bits
   logic [31:0]                                      sect_r;        // Sector size fields
   logic [31:0]                                      lss_r;         // Logical sector size
   logic [1:0]                                       flags_r;       // Quadword valid flags
   logic [31:0]                                      buf_lo_r;      // Buffer size low word
   logic [30:0]                                      buf_hi_r;      // Buffer size high bits

   // Bus answer flops
   // Ready stands one cycle
   logic                                             pready_r;
   logic [31:0]                                      prdata_r;
   logic                                             pslverr_r;

   // Decode wires
   // Region is PADDR 11:9
   wire [2:0]  region   = PADDR_IN[11:9];
   wire [6:0]  word_idx = PADDR_IN[8:2];
   wire        setup    = PSEL_IN && !PENABLE_IN;
   wire        wr_fire  = PSEL_IN && PENABLE_IN && PWRITE_IN && pready_r;
   wire        reg_hit  = (region == stream_log_pkg::REGION_REG) &&
                          (PADDR_IN <= stream_log_pkg::REG_STATUS) &&
                          (PADDR_IN[1:0] == 2'h0);
   wire        addr_ok  = (region == stream_log_pkg::REGION_LOG) ||
                          (region == stream_log_pkg::REGION_IDP) || reg_hit;

   // Quadword flag in the high half: the only bit set above 62 in any page
   // Used by capacity page
   function automatic logic [31:0] qw_hi(input logic flag, input logic [30:0] rest);
      qw_hi = {flag, rest};
   endfunction : qw_hi

   // Page header low word: page number in 23:16, revision in 15:0
   // Bit 63 goes via qw_hi
   function automatic logic [31:0] page_hdr(input logic [7:0] page);
      page_hdr = {8'h00, page, stream_log_pkg::PAGE_REV};
   endfunction : page_hdr

   // Capture enable for a new error
   // Unflagged strobes drop
   // stream flag gate
   wire        log_event = WS_ERR_VALID_IN && WS_ERR_STATUS_IN[stream_log_pkg::STATUS_SE_BIT];

   // Clear request from command logic or from software
   // Software clear: test hook
   // read clears log
   wire        clear_req = LOG_READ_DONE_IN ||
                           (wr_fire && (PADDR_IN == stream_log_pkg::REG_CTRL) &&
                            PWDATA_IN[stream_log_pkg::CTRL_CLEAR_BIT]);

   // After a clear the event still lands, so start from the empty state
   // Same-cycle error is entry 1
   wire [15:0] count_base = clear_req ? 16'h0000 : count_r;
   wire [4:0]  index_base = clear_req ? 5'h00 : index_r;
   wire [stream_log_pkg::LOG_ENTRIES-1:0] used_base =
               clear_req ? '0 : slot_used_r;

   // Next entry number wraps from 31 back to 1
   // Index 0 means empty
   // circular overwrite
   wire [4:0]  index_step = ((index_base == stream_log_pkg::INDEX_LAST) ||
                             (index_base == 5'h00)) ? stream_log_pkg::INDEX_FIRST
                                                    : index_base + 5'h01;
   wire [4:0]  slot_wr    = index_step - 5'h01;

   // New entry image in structure byte order
   // Reserved bytes read 0
   // entry field layout
   wire [127:0] entry_new = {16'h0000, WS_ERR_COUNT_IN,
                             16'h0000, WS_ERR_LBA_IN,
                             WS_ERR_ERROR_IN, WS_ERR_STATUS_IN, WS_ERR_FEATURE_IN};

   // Bookkeeping next values
   // One priority for clear
   // Clear first, then log
   always_comb
   begin
      count_nxt     = count_base;
      index_nxt     = index_base;
      slot_used_nxt = used_base;
      if (log_event)
      begin
         if (count_base != stream_log_pkg::COUNT_MAX)
            count_nxt = count_base + 16'h0001;
         index_nxt = index_step;
         slot_used_nxt[slot_wr] = 1'b1;
      end
   end

   // Log state; reset empties it so nothing survives a hardware reset
   // Reset acts as power-on
   // reset empties log
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (RESET_IN)
      begin
         count_r     <= 16'h0000;
         index_r     <= 5'h00;
         slot_used_r <= '0;
      end
      else
      begin
         count_r     <= count_nxt;
         index_r     <= index_nxt;
         slot_used_r <= slot_used_nxt;
      end
   end

   // Entry payload; no reset since the used bits hide stale slots
   // Saves a wide reset tree
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (log_event)
         entry_mem[slot_wr] <= entry_new;
   end

   // Identify copy load port; the host side never writes it
   // All 256 words reachable
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (ID_WR_EN_IN)
         id_mem[ID_WR_WORD_IN] <= ID_WR_DATA_IN;
   end

   // Log region read: header words, then entries of four words each
   // Slot is (word - 4) / 4
   // 512 byte structure
   wire [6:0]   ent_off  = word_idx - 7'(stream_log_pkg::HDR_WORDS);
   wire [4:0]   ent_slot = ent_off[6:2];
   wire [1:0]   ent_word = ent_off[1:0];
   wire         ent_live = (word_idx >= 7'(stream_log_pkg::HDR_WORDS)) &&
                           slot_used_r[ent_slot];
   wire [127:0] ent_data = ent_live ? entry_mem[ent_slot] : 128'h0;
   logic [31:0] log_word;

   always_comb
   begin
      log_word = 32'h0000_0000;
      if (word_idx == 7'h00)
         log_word = {count_r, 3'h0, index_r, stream_log_pkg::LOG_VERSION};
      else if (word_idx >= 7'(stream_log_pkg::HDR_WORDS))
         log_word = ent_data[ent_word*32 +: 32];
   end

   // Identify page read; words past the last field fall to zero
   // Byte n is word n/4
   // reserved tail zero
   wire [7:0]   id_lo_idx = {word_idx, 1'b0};
   wire [7:0]   id_hi_idx = {word_idx, 1'b1};
   logic [31:0] idp_word;

   always_comb
   begin
      idp_word = 32'h0000_0000;
      case (page_sel_r)
         stream_log_pkg::PG_LIST:
         begin
            case (word_idx)
               7'h00:   idp_word = page_hdr(stream_log_pkg::PG_LIST);
               7'h02:   idp_word = {stream_log_pkg::PG_CAP, stream_log_pkg::PG_IDCOPY,
                                    stream_log_pkg::PG_LIST, stream_log_pkg::PG_LIST_COUNT};
               default: idp_word = 32'h0000_0000;
            endcase
         end
         stream_log_pkg::PG_IDCOPY:
            idp_word = {id_mem[id_hi_idx], id_mem[id_lo_idx]};
         stream_log_pkg::PG_CAP:
         begin
            case (word_idx)
               7'h00:   idp_word = page_hdr(stream_log_pkg::PG_CAP);
               7'h01:   idp_word = qw_hi(1'b1, 31'h0);
               7'h02:   idp_word = cap_lo_r;
               7'h03:   idp_word = qw_hi(1'b1, {15'h0, cap_hi_r});
               7'h04:   idp_word = {10'h0, sect_r[stream_log_pkg::SECT_FIELD_W-1:0]};
               7'h05:   idp_word = {sect_r[stream_log_pkg::SECT_VALID_BIT],
                                    sect_r[stream_log_pkg::SECT_REL_SUP_BIT],
                                    sect_r[stream_log_pkg::SECT_LSS_SUP_BIT], 29'h0};
               7'h06:   idp_word = lss_r;
               7'h07:   idp_word = qw_hi(flags_r[stream_log_pkg::FLAG_LSS_VALID], 31'h0);
               7'h08:   idp_word = buf_lo_r;
               7'h09:   idp_word = qw_hi(flags_r[stream_log_pkg::FLAG_BUF_VALID], buf_hi_r);
               default: idp_word = 32'h0000_0000;
            endcase
         end
         default:
            idp_word = 32'h0000_0000;
      endcase
   end

   // Register region read
   // Control reads zero
   logic [31:0] reg_word;

   always_comb
   begin
      case (PADDR_IN)
         stream_log_pkg::REG_PAGE_SEL: reg_word = {24'h0, page_sel_r};
         stream_log_pkg::REG_CAP_LO:   reg_word = cap_lo_r;
         stream_log_pkg::REG_CAP_HI:   reg_word = {16'h0, cap_hi_r};
         stream_log_pkg::REG_SECT:     reg_word = sect_r;
         stream_log_pkg::REG_LSS:      reg_word = lss_r;
         stream_log_pkg::REG_FLAGS:    reg_word = {30'h0, flags_r};
         stream_log_pkg::REG_BUF_LO:   reg_word = buf_lo_r;
         stream_log_pkg::REG_BUF_HI:   reg_word = {1'b0, buf_hi_r};
         stream_log_pkg::REG_STATUS:   reg_word = {11'h0, index_r, count_r};
         default:                      reg_word = 32'h0000_0000;
      endcase
   end

   // Read mux by region; unmapped reads return zero
   // Writes read zero
   wire [31:0] rd_word = PWRITE_IN                                 ? 32'h0 :
                         (region == stream_log_pkg::REGION_LOG)    ? log_word :
                         (region == stream_log_pkg::REGION_IDP)    ? idp_word :
                         reg_hit                                   ? reg_word : 32'h0;

   // APB answer: data latched in setup so ready is high at the first access edge
   // No wait states
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (RESET_IN)
      begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup && !pready_r)
      begin
         pready_r  <= 1'b1;
         prdata_r  <= rd_word;
         pslverr_r <= !addr_ok;
      end
      else
      begin
         // Drop the answer once the access edge has passed
         // Read data holds
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   // Configuration writes; log and identify windows silently ignore writes
   // Unmapped writes do nothing
   // read-only pages
   always_ff @(posedge SYS_CLK_IN)
   begin
      if (RESET_IN)
      begin
         page_sel_r <= 8'h00;
         cap_lo_r   <= 32'h0000_0000;
         cap_hi_r   <= 16'h0000;
         sect_r     <= 32'h0000_0000;
         lss_r      <= 32'h0000_0000;
         flags_r    <= 2'h0;
         buf_lo_r   <= 32'h0000_0000;
         buf_hi_r   <= 31'h0000_0000;
      end
      else if (wr_fire && reg_hit)
      begin
         case (PADDR_IN)
            stream_log_pkg::REG_PAGE_SEL: page_sel_r <= PWDATA_IN[7:0];
            stream_log_pkg::REG_CAP_LO:   cap_lo_r   <= PWDATA_IN;
            stream_log_pkg::REG_CAP_HI:   cap_hi_r   <= PWDATA_IN[15:0];
            stream_log_pkg::REG_SECT:     sect_r     <= PWDATA_IN;
            stream_log_pkg::REG_LSS:      lss_r      <= PWDATA_IN;
            stream_log_pkg::REG_FLAGS:    flags_r    <= PWDATA_IN[1:0];
            stream_log_pkg::REG_BUF_LO:   buf_lo_r   <= PWDATA_IN;
            stream_log_pkg::REG_BUF_HI:   buf_hi_r   <= PWDATA_IN[30:0];
            default:                      page_sel_r <= page_sel_r;
         endcase
      end
   end

   // Outputs straight from flops
   // Count, index for debug
   assign PRDATA_OUT    = prdata_r;
   assign PREADY_OUT    = pready_r;
   assign PSLVERR_OUT   = pslverr_r;
   assign LOG_COUNT_OUT = count_r;
   assign LOG_INDEX_OUT = index_r;

endmodule : stream_error_and_identify_log

//--- stream_error_and_identify_log_properties.sv
/* Port assertions for the stream error and identify log block.
   Assumes it is bound into the block and shares its only clock. */
`timescale 1ns/1ps
module log_checker
(
   input wire logic        SYS_CLK_IN,
   input wire logic        RESET_IN,
   input wire logic        PSEL_IN,
   input wire logic        PENABLE_IN,
   input wire logic        PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PWDATA_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic        PREADY_OUT,
   input wire logic        PSLVERR_OUT,
   input wire logic        WS_ERR_VALID_IN,
   input wire logic [7:0]  WS_ERR_STATUS_IN,
   input wire logic        LOG_READ_DONE_IN,
   input wire logic [15:0] LOG_COUNT_OUT,
   input wire logic [4:0]  LOG_INDEX_OUT
);
   default clocking cb @(posedge SYS_CLK_IN);
   endclocking
   default disable iff (RESET_IN);
   // Qualified error strobe
   wire se  = WS_ERR_VALID_IN & WS_ERR_STATUS_IN[stream_log_pkg::STATUS_SE_BIT];
   // Completed APB write, and either source of a log clear
   wire wr  = PSEL_IN & PENABLE_IN & PWRITE_IN & PREADY_OUT;
   wire clr = LOG_READ_DONE_IN | (wr & (PADDR_IN == stream_log_pkg::REG_CTRL) & PWDATA_IN[0]);
   sequence s_setup;
      PSEL_IN && !PENABLE_IN && !PREADY_OUT;
   endsequence
   sequence s_answer;
      PREADY_OUT ##1 !PREADY_OUT;
   endsequence
   property p_no_wait;
      s_setup |=> s_answer;
   endproperty
   a_no_wait: assert property (p_no_wait) else $error("ready not one cycle after setup");
   property p_flag_only;
      !se && !clr |=> $stable(LOG_COUNT_OUT) && $stable(LOG_INDEX_OUT);
   endproperty
   a_flag_only: assert property (p_flag_only) else $error("log changed without flagged error");
   property p_count;
      se && !clr && LOG_COUNT_OUT != 16'hFFFF |=> LOG_COUNT_OUT == $past(LOG_COUNT_OUT) + 16'h0001;
   endproperty
   a_count: assert property (p_count) else $error("error count did not step");
   property p_sat;
      se && !clr && LOG_COUNT_OUT == 16'hFFFF |=> LOG_COUNT_OUT == 16'hFFFF;
   endproperty
   a_sat: assert property (p_sat) else $error("error count left saturation");
   property p_clear;
      clr && !se |=> LOG_COUNT_OUT == 16'h0000 && LOG_INDEX_OUT == 5'h00;
   endproperty
   a_clear: assert property (p_clear) else $error("clear did not empty log");
   property p_clear_log;
      clr && se |=> LOG_COUNT_OUT == 16'h0001 && LOG_INDEX_OUT == 5'h01;
   endproperty
   a_clear_log: assert property (p_clear_log) else $error("clear with error mis-logged");
   property p_index;
      se && !clr |=> LOG_INDEX_OUT == ($past(LOG_INDEX_OUT) == 5'h1F ? 5'h01 : $past(LOG_INDEX_OUT) + 5'h01);
   endproperty
   a_index: assert property (p_index) else $error("index did not advance or wrap");
   property p_empty;
      LOG_COUNT_OUT == 16'h0000 |-> LOG_INDEX_OUT == 5'h00;
   endproperty
   a_empty: assert property (p_empty) else $error("index set on empty log");
   property p_err_zero;
      PREADY_OUT && PSLVERR_OUT |-> PRDATA_OUT == 32'h00000000;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("refused access returned data");
endmodule : log_checker

bind stream_error_and_identify_log log_checker u_chk (.SYS_CLK_IN, .RESET_IN, .PSEL_IN,
   .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
   .WS_ERR_VALID_IN, .WS_ERR_STATUS_IN, .LOG_READ_DONE_IN, .LOG_COUNT_OUT, .LOG_INDEX_OUT);

//--- stream_log_pkg.sv
/*
 * Constants shared by the stream error and identify log block: APB map,
 * log structure layout, identify page contents and control fields.
 * Assumes a 32-bit APB with 12 address bits and a 100 MHz system clock.
 */
package stream_log_pkg;

   // Bus shape
   localparam int unsigned ADDR_W        = 12;
   localparam int unsigned DATA_W        = 32;

   // Address regions, selected by PADDR[11:9]
   localparam logic [2:0]  REGION_LOG    = 3'h0;   // Write stream error log, 512 bytes
   localparam logic [2:0]  REGION_IDP    = 3'h1;   // Selected identify log page
   localparam logic [2:0]  REGION_REG    = 3'h2;   // Control and configuration

   // Register byte offsets inside the whole map
   localparam logic [11:0] REG_CTRL      = 12'h400; // W: bit0 clears the log
   localparam logic [11:0] REG_PAGE_SEL  = 12'h404; // RW: identify page shown
   localparam logic [11:0] REG_CAP_LO    = 12'h408; // RW: capacity 31:0
   localparam logic [11:0] REG_CAP_HI    = 12'h40C; // RW: capacity 47:32
   localparam logic [11:0] REG_SECT      = 12'h410; // RW: sector size quadword fields
   localparam logic [11:0] REG_LSS       = 12'h414; // RW: logical sector size
   localparam logic [11:0] REG_FLAGS     = 12'h418; // RW: valid flags
   localparam logic [11:0] REG_BUF_LO    = 12'h41C; // RW: buffer size 31:0
   localparam logic [11:0] REG_BUF_HI    = 12'h420; // RW: buffer size 62:32
   localparam logic [11:0] REG_STATUS    = 12'h424; // RO: count and index

   // Control and configuration field positions
   localparam int unsigned CTRL_CLEAR_BIT   = 0;
   localparam int unsigned FLAG_LSS_VALID   = 0;
   localparam int unsigned FLAG_BUF_VALID   = 1;
   localparam int unsigned SECT_VALID_BIT   = 31;
   localparam int unsigned SECT_REL_SUP_BIT = 30;
   localparam int unsigned SECT_LSS_SUP_BIT = 29;
   localparam int unsigned SECT_FIELD_W     = 22;   // align 21:20, rel 19:16, offset 15:0
   localparam int unsigned STATUS_SE_BIT    = 5;    // Stream error flag in ATA status

   // Log structure
   localparam int unsigned LOG_ENTRIES   = 31;
   localparam int unsigned INDEX_W       = 5;
   localparam int unsigned COUNT_W       = 16;
   localparam int unsigned HDR_WORDS     = 4;      // 16 header bytes
   localparam int unsigned ENTRY_WORDS   = 4;      // 16 bytes per entry
   localparam logic [7:0]  LOG_VERSION   = 8'h02;
   localparam logic [4:0]  INDEX_LAST    = 5'h1F;  // Entry number 31
   localparam logic [4:0]  INDEX_FIRST   = 5'h01;  // Entry number 1
   localparam logic [15:0] COUNT_MAX     = 16'hFFFF;

   // Identify device data log pages
   localparam logic [7:0]  PG_LIST       = 8'h00;
   localparam logic [7:0]  PG_IDCOPY     = 8'h01;
   localparam logic [7:0]  PG_CAP        = 8'h02;
   localparam logic [7:0]  PG_LIST_COUNT = 8'h03;
   localparam logic [15:0] PAGE_REV      = 16'h0001;
   localparam int unsigned ID_WORDS      = 256;
   localparam int unsigned QW_FLAG_BIT   = 31;     // Bit 63 of a quadword, in the high word

endpackage : stream_log_pkg

//--- test_stream_error_and_identify_log.sv
/* Self-checking bench: APB reads and writes against expected values.
   Assumes err_reporter drives the error side; 100 MHz clock. */
`timescale 1ns/1ps
module test_stream_error_and_identify_log;
   logic        clk, rst, psel, pen, pwr, rdy, sle, sl, id_en, wsv, done;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [15:0] feat, cnt, id_data, lcount;
   logic [7:0]  stat, errv, id_word;
   logic [47:0] lba;
   logic [4:0]  lidx;
   int          mismatches, n_checks, cyc;
   stream_error_and_identify_log uut (.SYS_CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
      .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PRDATA_OUT(prdata), .PREADY_OUT(rdy), .PSLVERR_OUT(sle), .WS_ERR_VALID_IN(wsv),
      .WS_ERR_FEATURE_IN(feat), .WS_ERR_STATUS_IN(stat), .WS_ERR_ERROR_IN(errv),
      .WS_ERR_LBA_IN(lba), .WS_ERR_COUNT_IN(cnt), .LOG_READ_DONE_IN(done),
      .ID_WR_EN_IN(id_en), .ID_WR_WORD_IN(id_word), .ID_WR_DATA_IN(id_data),
      .LOG_COUNT_OUT(lcount), .LOG_INDEX_OUT(lidx));
   err_reporter src (.clk_in(clk), .valid_out(wsv), .feature_out(feat), .status_out(stat),
      .error_out(errv), .lba_out(lba), .count_out(cnt), .done_out(done));
   // Free-running clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task end_of_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : end_of_test
   // Hang guard, well above the saturation burst
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 70000)
      begin
         mismatches++;
         end_of_test();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
      n_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One APB transfer; request held until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rdv = prdata;
      sl  = sle;
      {psel, pen} <= 2'b00;
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h00000000);
      chk(rdv, e, nm);
   endtask : rd
   // Entry word w of the error with sequence number m
   function automatic logic [31:0] ew(input int m, input int w);
      case (w)
         0:       return {8'h04, 8'h21, m[15:0]};
         1:       return {16'h5A5A, m[15:0]};
         2:       return 32'h000000AB;
         default: return {16'h0000, m[15:0] + 16'h0001};
      endcase
   endfunction : ew
   initial
   begin
      {rst, psel, pen, pwr, paddr, pwdata, id_en, id_word, id_data} = '0;
      rst = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rd(12'h424, 32'h00000000, "status_reset");
      rd(12'h404, 32'h00000000, "page_sel_reset");
      rd(12'h000, 32'h00000002, "header_reset");
      src.send(0, 2, 1'b0);
      rd(12'h424, 32'h00000000, "unflagged");
      src.send(0, 3, 1'b1);
      rd(12'h000, 32'h00030302, "header_three");
      for (int w = 0; w < 4; w++) rd(12'(16 + 4 * w), ew(0, w), "entry_one");
      src.send(3, 31, 1'b1);
      rd(12'h424, 32'h00030022, "status_wrap");
      rd(12'h010, ew(31, 0), "entry_overwritten");
      rd(12'h1F0, ew(30, 0), "entry_last");
      src.done_pulse();
      rd(12'h424, 32'h00000000, "status_cleared");
      rd(12'h010, 32'h00000000, "entry_cleared");
      @(posedge clk);
      {id_en, id_word, id_data} <= {1'b1, 8'h00, 16'hBEEF};
      @(posedge clk);
      {id_word, id_data} <= {8'h01, 16'h1234};
      @(posedge clk);
      id_en <= 1'b0;
      apb(1'b1, 12'h404, 32'h00000001);
      rd(12'h200, 32'h1234BEEF, "identify_copy");
      apb(1'b1, 12'h200, 32'h00000000);
      rd(12'h200, 32'h1234BEEF, "identify_read_only");
      apb(1'b1, 12'h404, 32'h00000000);
      rd(12'h200, 32'h00000001, "list_header");
      rd(12'h208, 32'h02010003, "list_entries");
      apb(1'b1, 12'h404, 32'h00000003);
      rd(12'h200, 32'h00000000, "unsupported_page");
      apb(1'b1, 12'h404, 32'h00000002);
      rd(12'h200, 32'h00020001, "capacity_header_low");
      rd(12'h204, 32'h80000000, "capacity_header_high");
      apb(1'b1, 12'h408, 32'hCAFEF00D);
      apb(1'b1, 12'h40C, 32'h00001357);
      rd(12'h208, 32'hCAFEF00D, "capacity_low");
      rd(12'h20C, 32'h80001357, "capacity_high");
      apb(1'b1, 12'h410, 32'hE03FFFFF);
      rd(12'h210, 32'h003FFFFF, "sector_fields");
      rd(12'h214, 32'hE0000000, "sector_flags");
      apb(1'b1, 12'h418, 32'h00000003);
      apb(1'b1, 12'h414, 32'h00001000);
      rd(12'h218, 32'h00001000, "logical_size");
      rd(12'h21C, 32'h80000000, "logical_valid");
      apb(1'b1, 12'h420, 32'hFFFFFFFF);
      rd(12'h224, 32'hFFFFFFFF, "buffer_high");
      rd(12'h228, 32'h00000000, "reserved_tail");
      rd(12'h428, 32'h00000000, "unmapped_data");
      chk({31'h0, sl}, 32'h00000001, "unmapped_error");
      src.send(0, 65540, 1'b1);
      rd(12'h424, 32'h0006FFFF, "saturated");
      chk({11'h0, lidx, lcount}, 32'h0006FFFF, "log_ports");
      apb(1'b1, 12'h400, 32'h00000001);
      rd(12'h424, 32'h00000000, "register_clear");
      fork
         src.send(100, 1, 1'b1);
         src.done_pulse();
      join
      rd(12'h424, 32'h00010001, "clear_and_error");
      end_of_test();
   end
endmodule : test_stream_error_and_identify_log
